// file: dlt_pkg.sv
// constants and table contents for the ddr read latency table block
package dlt_pkg;

  // table geometry
  localparam int          DLT_ADDR_W     = 8;
  localparam int          DLT_DATA_W     = 8;
  localparam int          DLT_ROWS       = 5;
  localparam int          DLT_ROW_LEN    = 8;
  localparam int          DLT_HDR_BASE   = 4;
  localparam int          DLT_SDR_BYTES  = 3;
  localparam int          DLT_DDR_BYTES  = 44;
  localparam int          DLT_ROM_DEPTH  = DLT_SDR_BYTES + DLT_DDR_BYTES;
  localparam logic [7:0]  DLT_IDX_DDR    = 8'h03;
  localparam logic [7:0]  DLT_UNSUPP     = 8'hFF;

  // fields inside a row
  localparam int          DLT_FLD_FREQ   = 0;
  localparam int          DLT_FLD_CODE   = 1;
  localparam int          DLT_FLD_MODE0  = 2;
  localparam int          DLT_FLD_LAT0   = 3;
  localparam int          DLT_CMD_KINDS  = 3;

  // pin timing
  localparam int          DLT_SYNC_STAGES = 3;
  localparam int          DLT_BITS        = 8;
  localparam int          DLT_SCK_NS      = 160;
  localparam int          DLT_CLK_NS      = 20;
  localparam int          DLT_SCK_CYC     = DLT_SCK_NS / DLT_CLK_NS;

  typedef logic [7:0] dlt_byte_t;

  // tail of the single-rate table, highest-frequency row: unsupported
  localparam dlt_byte_t DLT_SDR_TAIL [0:DLT_SDR_BYTES-1] = '{8'hFF, 8'hFF, 8'hFF};

  // ddr latency parameter: id, length, rows, row length, then five rows
  localparam dlt_byte_t DLT_DDR_TBL [0:DLT_DDR_BYTES-1] = '{
    8'h9A, 8'h2A, 8'h05, 8'h08,
    8'h46, 8'h43, 8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE,
    8'h32, 8'h03, 8'h00, 8'h04, 8'h00, 8'h04, 8'h01, 8'h03,
    8'h42, 8'h00, 8'h00, 8'h05, 8'h00, 8'h06, 8'h01, 8'h06,
    8'h42, 8'h01, 8'h00, 8'h06, 8'h00, 8'h07, 8'h01, 8'h07,
    8'h42, 8'h02, 8'h00, 8'h07, 8'h00, 8'h08, 8'h01, 8'h08
  };

  // byte offset of a row inside the ddr parameter
  function automatic int dlt_row_base(input int row);
    return DLT_HDR_BASE + row * DLT_ROW_LEN;
  endfunction

endpackage

// file: dlt_tbl_if.sv
// read port between the query engine and the table memory
`timescale 1ns/1ns
interface dlt_tbl_if #(
  parameter int AW = 8
);
  logic          rd_en;
  logic [AW-1:0] addr;
  logic [7:0]    rdata;
  logic          rvalid;

  modport req (output rd_en, output addr, input rdata, input rvalid);
  modport rom (input rd_en, input addr, output rdata, output rvalid);
endinterface

// file: dlt_rom.sv
// table memory with registered read data
`timescale 1ns/1ns
module dlt_rom (
  // clock and control
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // read port
  dlt_tbl_if.rom    rd
);
  import dlt_pkg::*;

  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;
  logic       rvalid_d;

  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = rd.rd_en;
    if (rd.rd_en) begin
      if (rd.addr < DLT_IDX_DDR) begin
        rdata_d = DLT_SDR_TAIL[rd.addr[1:0]];
      end else if (int'(rd.addr) < DLT_ROM_DEPTH) begin
        rdata_d = DLT_DDR_TBL[int'(rd.addr - DLT_IDX_DDR)];
      end else begin
        rdata_d = DLT_UNSUPP;  // beyond the table reads as erased
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else if (ce_i) begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign rd.rdata  = rdata_q;
  assign rd.rvalid = rvalid_q;
endmodule

// file: dlt_pin_sync.sv
// three-stage pin synchroniser, change taken once stages two and three agree
`timescale 1ns/1ns
module dlt_pin_sync #(
  parameter int          WIDTH = 3,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and control
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // pins and filtered result
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] pin_o
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] out_d;

  if (WIDTH < 1) begin : g_chk_width
    $error("synchroniser needs at least one pin");
  end

  // stage one feeds only stage two to keep metastability contained
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s1_q  <= INIT;
      s2_q  <= INIT;
      s3_q  <= INIT;
      out_q <= INIT;
    end else if (ce_i) begin
      s1_q  <= pin_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign pin_o = out_q;
endmodule

// file: dlt_top.sv
// ddr read latency table: serial query port and latency lookup
`timescale 1ns/1ns
module dlt_top (
  // clock, reset, enable
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  // serial query pins
  input  wire logic                  sck_i,
  input  wire logic                  cs_n_i,
  input  wire logic                  si_i,
  output logic                       so_o,
  output logic                       so_oe_o,
  // latency lookup
  input  wire logic [1:0]            lat_code_i,
  input  wire dlt_pkg::dlt_byte_t    opcode_i,
  output dlt_pkg::dlt_byte_t         mode_cycles_o,
  output dlt_pkg::dlt_byte_t         lat_cycles_o,
  output dlt_pkg::dlt_byte_t         freq_limit_o,
  output logic                       supported_o
);
  import dlt_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DATA
  } dlt_state_e;

  typedef struct packed {
    dlt_byte_t mode;
    dlt_byte_t lat;
    dlt_byte_t freq;
    logic      sup;
  } dlt_look_s;

  // elaboration checks on the geometry and timing the logic relies on
  if (DLT_ROM_DEPTH > (1 << DLT_ADDR_W)) begin : g_chk_depth
    $error("table does not fit the address width");
  end
  // the read path needs a few core cycles between serial edges
  if (DLT_SCK_CYC < 6) begin : g_chk_sck
    $error("serial clock too fast for the table read path");
  end
  // length byte plus its own location plus one closes the parameter
  if (int'(DLT_DDR_TBL[1]) + 2 != DLT_DDR_BYTES) begin : g_chk_len
    $error("parameter length byte disagrees with the table size");
  end
  if (int'(DLT_DDR_TBL[2]) != DLT_ROWS || int'(DLT_DDR_TBL[3]) != DLT_ROW_LEN) begin : g_chk_geom
    $error("row count or row length byte disagrees with the geometry");
  end
  if (DLT_HDR_BASE + DLT_ROWS * DLT_ROW_LEN != DLT_DDR_BYTES) begin : g_chk_rows
    $error("rows do not fill the parameter");
  end
  if (DLT_FLD_LAT0 + 2 * (DLT_CMD_KINDS - 1) >= DLT_ROW_LEN) begin : g_chk_cols
    $error("command columns overrun a row");
  end
  if (DLT_SYNC_STAGES != 3) begin : g_chk_sync
    $error("pin path is built for three synchroniser stages");
  end

  // one byte of the ddr parameter, by row and field
  function automatic dlt_byte_t row_byte(input int row, input int fld);
    return DLT_DDR_TBL[dlt_row_base(row) + fld];
  endfunction

  // command kind from the header opcode columns, -1 when nothing matches
  function automatic int opcode_kind(input dlt_byte_t op);
    int kind;
    kind = -1;
    // opcodes sit over the mode and latency columns: 3-byte then 4-byte address
    for (int k = 0; k < 2 * DLT_CMD_KINDS; k++) begin
      if (row_byte(0, DLT_FLD_MODE0 + k) == op) begin
        kind = k / 2;
      end
    end
    return kind;
  endfunction

  // answer for one opcode and latency code; no match reads as unsupported
  function automatic dlt_look_s lookup(input dlt_byte_t op, input logic [1:0] code);
    dlt_look_s res;
    int        kind;
    res.mode = DLT_UNSUPP;
    res.lat  = DLT_UNSUPP;
    res.freq = 8'h00;
    kind     = opcode_kind(op);
    // first matching row wins, which keeps the lowest frequency limit
    for (int r = DLT_ROWS - 1; r >= 1; r--) begin
      if (kind >= 0 && row_byte(r, DLT_FLD_CODE) == {6'h00, code}) begin
        res.mode = row_byte(r, DLT_FLD_MODE0 + 2 * kind);
        res.lat  = row_byte(r, DLT_FLD_LAT0 + 2 * kind);
        res.freq = row_byte(r, DLT_FLD_FREQ);
      end
    end
    // an all-ones byte marks the command as unsupported at that row
    res.sup = (res.mode != DLT_UNSUPP) && (res.lat != DLT_UNSUPP);
    return res;
  endfunction

  // last bit of a serial byte, shared by address and data phases
  function automatic logic last_bit(input logic [2:0] cnt);
    return cnt == 3'(DLT_BITS - 1);
  endfunction

  // pin synchronisation
  logic [2:0] pins_s;
  logic       sck_s;
  logic       cs_n_s;
  logic       si_s;

  dlt_pin_sync #(
    .WIDTH (3),
    .INIT  (3'b010)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .pin_i      ({sck_i, cs_n_i, si_i}),
    .pin_o      (pins_s)
  );

  assign sck_s  = pins_s[2];
  assign cs_n_s = pins_s[1];
  assign si_s   = pins_s[0];

  // table memory
  dlt_tbl_if #(.AW(DLT_ADDR_W)) tbl ();

  dlt_rom u_rom (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .rd         (tbl.rom)
  );

  // serial query engine
  dlt_state_e        state_q;
  dlt_state_e        state_d;
  logic              sck_prev_q;
  logic              sck_prev_d;
  logic [2:0]        bit_cnt_q;
  logic [2:0]        bit_cnt_d;
  logic [7:0]        addr_q;
  logic [7:0]        addr_d;
  logic [7:0]        sh_q;
  logic [7:0]        sh_d;
  logic              so_q;
  logic              so_d;
  logic              so_oe_q;
  logic              so_oe_d;
  logic              rd_en_q;
  logic              rd_en_d;
  logic              sck_rise;
  logic              sck_fall;

  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;

  // bytes stream out msb first from the addressed byte, address auto-increments
  always_comb begin
    state_d    = state_q;
    sck_prev_d = sck_s;
    bit_cnt_d  = bit_cnt_q;
    addr_d     = addr_q;
    sh_d       = sh_q;
    so_d       = so_q;
    so_oe_d    = so_oe_q;
    rd_en_d    = 1'b0;
    if (tbl.rvalid) begin
      sh_d = tbl.rdata;
    end
    if (cs_n_s) begin
      state_d   = ST_IDLE;
      so_oe_d   = 1'b0;
      bit_cnt_d = 3'd0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          state_d   = ST_ADDR;
          bit_cnt_d = 3'd0;
        end
        ST_ADDR: begin
          if (sck_rise) begin
            addr_d    = {addr_q[6:0], si_s};
            bit_cnt_d = bit_cnt_q + 3'd1;
            if (last_bit(bit_cnt_q)) begin
              state_d = ST_DATA;
              rd_en_d = 1'b1;
            end
          end
        end
        ST_DATA: begin
          // output changes on the falling edge, host samples just before the next falling one
          if (sck_fall) begin
            so_oe_d   = 1'b1;
            so_d      = sh_q[7];
            sh_d      = {sh_q[6:0], 1'b0};
            bit_cnt_d = bit_cnt_q + 3'd1;
            if (last_bit(bit_cnt_q)) begin
              addr_d  = addr_q + 8'h01;
              rd_en_d = 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q    <= ST_IDLE;
      sck_prev_q <= 1'b0;
      bit_cnt_q  <= 3'd0;
      addr_q     <= 8'h00;
      sh_q       <= 8'h00;
      so_q       <= 1'b0;
      so_oe_q    <= 1'b0;
      rd_en_q    <= 1'b0;
    end else if (ce_i) begin
      state_q    <= state_d;
      sck_prev_q <= sck_prev_d;
      bit_cnt_q  <= bit_cnt_d;
      addr_q     <= addr_d;
      sh_q       <= sh_d;
      so_q       <= so_d;
      so_oe_q    <= so_oe_d;
      rd_en_q    <= rd_en_d;
    end
  end

  // the read address is the new byte address, seen one cycle after the request
  assign tbl.rd_en = rd_en_q;
  assign tbl.addr  = addr_q;
  assign so_o      = so_q;
  assign so_oe_o   = so_oe_q;

  // latency lookup: header opcode column picks the field, code picks the row
  dlt_byte_t mode_q;
  dlt_byte_t mode_d;
  dlt_byte_t lat_q;
  dlt_byte_t lat_d;
  dlt_byte_t freq_q;
  dlt_byte_t freq_d;
  logic      sup_q;
  logic      sup_d;

  always_comb begin
    dlt_look_s look;
    look   = lookup(opcode_i, lat_code_i);
    mode_d = look.mode;
    lat_d  = look.lat;
    freq_d = look.freq;
    sup_d  = look.sup;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mode_q <= DLT_UNSUPP;
      lat_q  <= DLT_UNSUPP;
      freq_q <= 8'h00;
      sup_q  <= 1'b0;
    end else if (ce_i) begin
      mode_q <= mode_d;
      lat_q  <= lat_d;
      freq_q <= freq_d;
      sup_q  <= sup_d;
    end
  end

  assign mode_cycles_o = mode_q;
  assign lat_cycles_o  = lat_q;
  assign freq_limit_o  = freq_q;
  assign supported_o   = sup_q;
endmodule

// file: dlt_top_properties.sv
// checker for the ddr latency lookup port and the serial query pins
`timescale 1ns/1ns
module dlt_top_properties
  import dlt_pkg::*;
(
  // clock and control
  input wire logic      core_clk_i,
  input wire logic      rst_i,
  input wire logic      ce_i,
  // serial pins
  input wire logic      sck_i,
  input wire logic      cs_n_i,
  input wire logic      si_i,
  input wire logic      so_o,
  input wire logic      so_oe_o,
  // lookup port
  input wire logic [1:0] lat_code_i,
  input wire dlt_byte_t opcode_i,
  input wire dlt_byte_t mode_cycles_o,
  input wire dlt_byte_t lat_cycles_o,
  input wire dlt_byte_t freq_limit_o,
  input wire logic      supported_o
);
  logic fast;
  logic dual;
  logic quad;
  assign fast = (opcode_i == 8'h0D) || (opcode_i == 8'h0E);
  assign dual = (opcode_i == 8'hBD) || (opcode_i == 8'hBE);
  assign quad = (opcode_i == 8'hED) || (opcode_i == 8'hEE);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  AST_FAST: assert property (
    ce_i && fast |=> supported_o && mode_cycles_o == 8'h00 &&
    lat_cycles_o == ($past(lat_code_i) == 2'd3 ? 8'h04 : 8'h05 + $past(lat_code_i)))
    else $error("fast ddr lookup wrong");
  AST_DUAL: assert property (
    ce_i && dual |=> supported_o && mode_cycles_o == 8'h00 &&
    lat_cycles_o == ($past(lat_code_i) == 2'd3 ? 8'h04 : 8'h06 + $past(lat_code_i)))
    else $error("dual ddr lookup wrong");
  AST_QUAD: assert property (
    ce_i && quad |=> supported_o && mode_cycles_o == 8'h01 &&
    lat_cycles_o == ($past(lat_code_i) == 2'd3 ? 8'h03 : 8'h06 + $past(lat_code_i)))
    else $error("quad ddr lookup wrong");
  AST_FREQ: assert property (ce_i && (fast || dual || quad) |=>
    freq_limit_o == ($past(lat_code_i) == 2'd3 ? 8'h32 : 8'h42)) else $error("freq limit wrong");
  AST_UNKNOWN: assert property (ce_i && !(fast || dual || quad) |=> !supported_o &&
    lat_cycles_o == 8'hFF && mode_cycles_o == 8'hFF && freq_limit_o == 8'h00)
    else $error("unknown opcode answered");
  AST_OE_IDLE: assert property ((ce_i && cs_n_i) [*8] |-> !so_oe_o)
    else $error("so driven while deselected");
  AST_OE_CS: assert property ($rose(so_oe_o) |-> !cs_n_i && !$past(cs_n_i, 4))
    else $error("so enabled without select");
  AST_SO_HOLD: assert property (so_oe_o && $changed(so_o) |=> $stable(so_o) [*3])
    else $error("so bit too short");
endmodule
bind dlt_top dlt_top_properties chk (.core_clk_i, .rst_i, .ce_i, .sck_i, .cs_n_i, .si_i,
  .so_o, .so_oe_o, .lat_code_i, .opcode_i, .mode_cycles_o, .lat_cycles_o, .freq_limit_o,
  .supported_o);

// file: dlt_host_model.sv
// serial host that sends a table index in mode 0 and collects bytes
`timescale 1ns/1ns
module dlt_host_model (
  // serial pins
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o,
  input  wire logic so_i,
  input  wire logic so_oe_i
);
  logic [7:0] rx [0:15];
  int         bad_oe = 0;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // 160 ns period, well under either row limit; sck idles low between frames
  task automatic xfer(input logic [7:0] idx, input int n);
    cs_n_o = 1'b0;
    #160;
    for (int i = 7; i >= 0; i--) begin
      si_o = idx[i];
      #80 sck_o = 1'b1;
      #80 sck_o = 1'b0;
    end
    si_o = ~si_o;
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        #80 sck_o = 1'b1;
        // sample late: the pin path delays so by about five core cycles
        // a released line reads inverted, so a late enable shows up as bad data
        #79 rx[b][i] = so_oe_i ? so_i : ~so_i;
        if (so_oe_i !== 1'b1) bad_oe++;
        #1 sck_o = 1'b0;
      end
    end
    #80 cs_n_o = 1'b1;
    si_o = ~si_o;
    #240;
  endtask
endmodule

// file: dlt_top_bench.sv
// self-checking bench for the ddr latency table
`timescale 1ns/1ns
module dlt_top_bench;
  import dlt_pkg::*;
  logic       core_clk_i;
  logic       rst_i;
  logic       ce_i;
  logic       sck;
  logic       cs_n;
  logic       si;
  logic       so_o;
  logic       so_oe_o;
  logic       supported_o;
  logic [1:0] lat_code_i;
  dlt_byte_t  opcode_i;
  dlt_byte_t  mode_cycles_o;
  dlt_byte_t  lat_cycles_o;
  dlt_byte_t  freq_limit_o;
  int         err_total = 0;
  int         compares = 0;
  localparam logic [7:0] OPS [0:5] = '{8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE};
  localparam logic [7:0] LAT [0:2][0:3] = '{'{8'h05, 8'h06, 8'h07, 8'h04},
    '{8'h06, 8'h07, 8'h08, 8'h04}, '{8'h06, 8'h07, 8'h08, 8'h03}};
  localparam logic [7:0] HEAD [0:14] = '{8'hFF, 8'hFF, 8'hFF, 8'h9A, 8'h2A, 8'h05, 8'h08,
    8'h46, 8'h43, 8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE};
  localparam logic [7:0] BAD [0:3] = '{8'h03, 8'h0B, 8'hEB, 8'hFF};
  dlt_top dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .sck_i(sck),
    .cs_n_i(cs_n), .si_i(si), .so_o(so_o), .so_oe_o(so_oe_o), .lat_code_i(lat_code_i),
    .opcode_i(opcode_i), .mode_cycles_o(mode_cycles_o), .lat_cycles_o(lat_cycles_o),
    .freq_limit_o(freq_limit_o), .supported_o(supported_o));
  dlt_host_model host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so_o), .so_oe_i(so_oe_o));
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_sim();
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic step();
    @(posedge core_clk_i);
    #2;
  endtask
  // every opcode under every code, a new request each cycle
  task automatic test_lookup();
    for (int o = 0; o < 6; o++) begin
      for (int c = 0; c < 4; c++) begin
        opcode_i = OPS[o];
        lat_code_i = c[1:0];
        step();
        chk("lat", LAT[o/2][c], lat_cycles_o);
        chk("mode", (o / 2 == 2) ? 8'h01 : 8'h00, mode_cycles_o);
        chk("freq", (c == 3) ? 8'h32 : 8'h42, freq_limit_o);
        chk("sup", 8'h01, {7'h00, supported_o});
        chk("dummy", ((o / 2 == 2) ? 8'h01 : 8'h00) + LAT[o/2][c],
          mode_cycles_o + lat_cycles_o);
      end
    end
  endtask
  task automatic test_unknown();
    for (int o = 0; o < 4; o++) begin
      opcode_i = BAD[o];
      lat_code_i = o[1:0];
      step();
      chk("lat_bad", 8'hFF, lat_cycles_o);
      chk("sup_bad", 8'h00, {7'h00, supported_o});
    end
  endtask
  // frozen with the enable low, then the held request lands
  task automatic test_freeze();
    ce_i = 1'b0;
    opcode_i = 8'hED;
    lat_code_i = 2'b11;
    repeat (3) step();
    chk("lat_frz", 8'hFF, lat_cycles_o);
    ce_i = 1'b1;
    step();
    chk("lat_run", 8'h03, lat_cycles_o);
  endtask
  task automatic test_serial();
    host.xfer(8'h00, 15);
    for (int b = 0; b < 15; b++) chk("head", HEAD[b], host.rx[b]);
    host.xfer(8'h2D, 3);
    chk("tail0", 8'h01, host.rx[0]);
    chk("tail1", 8'h08, host.rx[1]);
    chk("past_end", 8'hFF, host.rx[2]);
    chk("so_oe", 8'h00, host.bad_oe[7:0]);
  endtask
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    lat_code_i = 2'b00;
    opcode_i = 8'h00;
    repeat (5) @(posedge core_clk_i);
    #2;
    chk("rst_lat", 8'hFF, lat_cycles_o);
    chk("rst_oe", 8'h00, {7'h00, so_oe_o});
    rst_i = 1'b0;
    repeat (5) step();
    test_lookup();
    test_unknown();
    test_freeze();
    test_serial();
    end_sim();
  end
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
endmodule
